// file: fifo_host_defs.svh
`ifndef FIFO_HOST_DEFS_SVH
`define FIFO_HOST_DEFS_SVH

// Strobe high time in ns and in clock cycles (least time, rounds up)
`define STROBE_HIGH_NS 20
`define CLK_PERIOD_NS 10
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Strobe low time in ns and cycles
`define STROBE_LOW_NS 45
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Blocking window after first data-valid rise, ns and cycles
`define WINDOW_NS 40
`define WINDOW_CYC ((`WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Clear pulse width, ns and cycles
`define CLEAR_NS 40
`define CLEAR_CYC ((`CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Clear release to first write strobe, ns and cycles
`define CLEAR_TO_WR_NS 40
`define CLEAR_TO_WR_CYC ((`CLEAR_TO_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Buffer capacity of the device
`define DEV_DEPTH 64
// Host-side staging FIFO depth
`define STAGE_DEPTH 4
// Counter width for all timers
`define TMR_W 4

`endif

// file: fifo_host_pkg.sv
package fifo_host_pkg;
  typedef enum logic [2:0] {
    WR_CLEAR,
    WR_SETTLE,
    WR_IDLE,
    WR_HIGH,
    WR_LOW
  } wr_state_t;

  typedef enum logic [2:0] {
    RD_IDLE,
    RD_WINDOW,
    RD_HIGH,
    RD_WAIT_DROP,
    RD_LOW
  } rd_state_t;
endpackage

// file: stage_fifo.sv
module stage_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic in_valid, // Source has a word
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes word
  output logic [WIDTH-1:0] out_data // Word out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("stage_fifo: DEPTH power of two >= 2");
    if (WIDTH < 1) $error("stage_fifo: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Honest flags from the fill count
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // stage_fifo

// file: fifo_host.sv
// Behaviour
// - Strobes derived from ready flags only.
// - Pulse violation needs clear, data lost.
// - Block reads 40 ns after empty write.
// - Or read only past half full.
// - Hold first read 40 ns after valid.
// - Keep read high until valid drops.
// - Latch output word on read rise.
// - Width expansion ANDs flags of devices.
`include "fifo_host_defs.svh"

module fifo_host #(
  parameter int WIDTH = 5,
  parameter int LANES = 1,
  parameter int STAGE_DEPTH = `STAGE_DEPTH
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic clear_req, // Pulse: request device clear
  input wire logic src_valid, // Source word available
  output logic src_ready, // Staging FIFO has room
  input wire logic [WIDTH*LANES-1:0] src_data, // Source word
  output logic snk_valid, // Received word valid pulse
  output logic [WIDTH*LANES-1:0] snk_data, // Received word
  output logic busy_clear, // Clear in progress
  output logic clear_n, // Device clear, active low
  output logic wr_strobe, // Device write strobe
  output logic [WIDTH*LANES-1:0] wr_data, // Device input word
  input wire logic [LANES-1:0] space_available, // Device space flags
  output logic rd_strobe, // Device read strobe
  input wire logic [LANES-1:0] data_valid, // Device data-valid flags
  input wire logic [WIDTH*LANES-1:0] rd_data // Device output word
);
  localparam int TW = `TMR_W;
  localparam logic [TW-1:0] HI_CYC = TW'(`STROBE_HIGH_CYC);
  localparam logic [TW-1:0] LO_CYC = TW'(`STROBE_LOW_CYC);
  localparam logic [TW-1:0] WIN_CYC = TW'(`WINDOW_CYC);
  localparam logic [TW-1:0] CLR_CYC = TW'(`CLEAR_CYC);
  localparam logic [TW-1:0] SET_CYC = TW'(`CLEAR_TO_WR_CYC);
  localparam int DW = WIDTH * LANES;

  initial begin
    if (WIDTH != 4 && WIDTH != 5) $error("fifo_host: WIDTH must be 4 or 5");
    if (LANES < 1) $error("fifo_host: LANES must be positive");
  end

  // Synchronisers for device flags and data
  logic [LANES-1:0] sa_m_q, sa_q, dv_m_q, dv_q;
  logic [DW-1:0] rdd_m_q, rdd_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sa_m_q <= '0;
      sa_q <= '0;
      dv_m_q <= '0;
      dv_q <= '0;
      rdd_m_q <= '0;
      rdd_q <= '0;
    end else begin
      sa_m_q <= space_available;
      sa_q <= sa_m_q;
      dv_m_q <= data_valid;
      dv_q <= dv_m_q;
      rdd_m_q <= rd_data;
      rdd_q <= rdd_m_q;
    end
  end

  // Composite flags across parallel devices
  logic all_space, all_valid, any_valid;
  assign all_space = &sa_q;
  assign all_valid = &dv_q;
  assign any_valid = |dv_q;

  // Staging FIFO in front of the write side
  logic stg_valid, stg_pop;
  logic [DW-1:0] stg_data;
  stage_fifo #(.WIDTH(DW), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk(clk),
    .rst(rst),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data(src_data),
    .out_valid(stg_valid),
    .out_ready(stg_pop),
    .out_data(stg_data)
  );

  // Write side state
  fifo_host_pkg::wr_state_t wst_q;
  logic [TW-1:0] wtmr_q;
  logic clear_pend_q;
  logic empty_wr_q; // Write issued while device known empty
  logic rst_q; // Reset delayed by one cycle
  logic dev_empty_q; // Device known empty from the host's view
  logic rst_d_low; // Delayed reset is low
  logic rd_fell_q; // Read strobe has just fallen

  // Pending clear request, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      clear_pend_q <= 1'b1;
    end else if (clear_req) begin
      clear_pend_q <= 1'b1;
    end else if (wst_q == fifo_host_pkg::WR_CLEAR) begin
      clear_pend_q <= 1'b0;
    end
  end

  // Write strobe sequencer: strobe rises only on space, stays high until space drops
  // A pending clear must not pop a word that would then never be written
  assign stg_pop = (wst_q == fifo_host_pkg::WR_IDLE) && stg_valid && all_space &&
                   !clear_pend_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      wst_q <= fifo_host_pkg::WR_CLEAR;
      wtmr_q <= '0;
      wr_data <= '0;
      empty_wr_q <= 1'b0;
    end else begin
      empty_wr_q <= 1'b0;
      unique case (wst_q)
        fifo_host_pkg::WR_CLEAR: begin
          // Strobe held low through release so space rises, nothing stored
          wtmr_q <= wtmr_q + 1'b1;
          if (wtmr_q >= CLR_CYC - 1'b1) begin
            wst_q <= fifo_host_pkg::WR_SETTLE;
            wtmr_q <= '0;
          end
        end
        fifo_host_pkg::WR_SETTLE: begin
          wtmr_q <= wtmr_q + 1'b1;
          if (wtmr_q >= SET_CYC - 1'b1) begin
            wst_q <= fifo_host_pkg::WR_IDLE;
            wtmr_q <= '0;
          end
        end
        fifo_host_pkg::WR_IDLE: begin
          if (clear_pend_q) begin
            wst_q <= fifo_host_pkg::WR_CLEAR;
            wtmr_q <= '0;
          end else if (stg_pop) begin
            wr_data <= stg_data;
            empty_wr_q <= ~any_valid && (rst_q == 1'b0) && dev_empty_q;
            wst_q <= fifo_host_pkg::WR_HIGH;
            wtmr_q <= '0;
          end
        end
        fifo_host_pkg::WR_HIGH: begin
          // Hold high at least the minimum, and until space flag drops
          if (wtmr_q < HI_CYC) wtmr_q <= wtmr_q + 1'b1;
          if (wtmr_q >= HI_CYC - 1'b1 && !all_space) begin
            wst_q <= fifo_host_pkg::WR_LOW;
            wtmr_q <= '0;
          end
        end
        fifo_host_pkg::WR_LOW: begin
          wtmr_q <= wtmr_q + 1'b1;
          if (wtmr_q >= LO_CYC - 1'b1) begin
            wst_q <= fifo_host_pkg::WR_IDLE;
            wtmr_q <= '0;
          end
        end
      endcase
    end
  end

  assign wr_strobe = (wst_q == fifo_host_pkg::WR_HIGH);
  assign clear_n = (wst_q != fifo_host_pkg::WR_CLEAR);
  assign busy_clear = (wst_q == fifo_host_pkg::WR_CLEAR) || (wst_q == fifo_host_pkg::WR_SETTLE);

  // Tracks whether the device is empty from the host's view
  always_ff @(posedge clk) begin
    rst_q <= rst;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dev_empty_q <= 1'b1;
    end else if (wst_q == fifo_host_pkg::WR_CLEAR) begin
      dev_empty_q <= 1'b1;
    end else if (wr_strobe) begin
      dev_empty_q <= 1'b0;
    end else if (rst_d_low && !any_valid && rd_fell_q) begin
      dev_empty_q <= 1'b1;
    end
  end
  assign rst_d_low = ~rst_q;

  // Read side state
  fifo_host_pkg::rd_state_t rst_st_q;
  logic [TW-1:0] rtmr_q;
  logic first_q; // Next valid rise is the first after empty

  // Arm the first-read hold when a write meets an empty device
  always_ff @(posedge clk) begin
    if (rst || wst_q == fifo_host_pkg::WR_CLEAR) begin
      first_q <= 1'b1;
    end else if (empty_wr_q) begin
      first_q <= 1'b1;
    end else if (rst_st_q == fifo_host_pkg::RD_WINDOW) begin
      first_q <= 1'b0;
    end
  end

  // Read strobe sequencer with handshake on data-valid
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_st_q <= fifo_host_pkg::RD_IDLE;
      rtmr_q <= '0;
      snk_valid <= 1'b0;
      snk_data <= '0;
      rd_fell_q <= 1'b0;
    end else begin
      snk_valid <= 1'b0;
      rd_fell_q <= 1'b0;
      unique case (rst_st_q)
        fifo_host_pkg::RD_IDLE: begin
          rtmr_q <= '0;
          if (all_valid && clear_n && !busy_clear) begin
            rst_st_q <= first_q ? fifo_host_pkg::RD_WINDOW : fifo_host_pkg::RD_HIGH;
            if (!first_q) begin
              snk_data <= rdd_q;
              snk_valid <= 1'b1;
            end
          end
        end
        fifo_host_pkg::RD_WINDOW: begin
          // Wait out the ignore window after the first valid rise
          rtmr_q <= rtmr_q + 1'b1;
          if (rtmr_q >= WIN_CYC - 1'b1) begin
            rst_st_q <= fifo_host_pkg::RD_HIGH;
            rtmr_q <= '0;
            snk_data <= rdd_q;
            snk_valid <= 1'b1;
          end
        end
        fifo_host_pkg::RD_HIGH: begin
          if (rtmr_q < HI_CYC) rtmr_q <= rtmr_q + 1'b1;
          if (rtmr_q >= HI_CYC - 1'b1) begin
            rst_st_q <= fifo_host_pkg::RD_WAIT_DROP;
          end
        end
        fifo_host_pkg::RD_WAIT_DROP: begin
          // Strobe stays high until every device drops valid
          if (!any_valid) begin
            rst_st_q <= fifo_host_pkg::RD_LOW;
            rtmr_q <= '0;
            rd_fell_q <= 1'b1;
          end
        end
        fifo_host_pkg::RD_LOW: begin
          rtmr_q <= rtmr_q + 1'b1;
          if (rtmr_q >= LO_CYC - 1'b1) begin
            rst_st_q <= fifo_host_pkg::RD_IDLE;
            rtmr_q <= '0;
          end
        end
      endcase
      if (wst_q == fifo_host_pkg::WR_CLEAR) begin
        rst_st_q <= fifo_host_pkg::RD_IDLE;
        rtmr_q <= '0;
      end
    end
  end

  assign rd_strobe = (rst_st_q == fifo_host_pkg::RD_HIGH) ||
                     (rst_st_q == fifo_host_pkg::RD_WAIT_DROP);
endmodule // fifo_host

// file: fifo_host_checker.sv
module fifo_host_checker #(
  parameter int WIDTH = 5,
  parameter int LANES = 1
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic clear_req, // Clear request
  input wire logic src_valid, // Source valid
  input wire logic src_ready, // Source ready
  input wire logic [WIDTH*LANES-1:0] src_data, // Source word
  input wire logic snk_valid, // Sink pulse
  input wire logic [WIDTH*LANES-1:0] snk_data, // Sink word
  input wire logic busy_clear, // Clear running
  input wire logic clear_n, // Device clear
  input wire logic wr_strobe, // Write strobe
  input wire logic [WIDTH*LANES-1:0] wr_data, // Device word
  input wire logic [LANES-1:0] space_available, // Room flags
  input wire logic rd_strobe, // Read strobe
  input wire logic [LANES-1:0] data_valid, // Valid flags
  input wire logic [WIDTH*LANES-1:0] rd_data // Device output
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Strobe phases
  sequence s_held(sig); sig [*2]; endsequence
  sequence s_rest(sig); !sig [*5]; endsequence
  property p_wr_high; $rose(wr_strobe) |-> s_held(wr_strobe); endproperty
  a_wr_high: assert property (p_wr_high) else $error("write strobe too short");
  property p_wr_low; $fell(wr_strobe) |-> s_rest(wr_strobe); endproperty
  a_wr_low: assert property (p_wr_low) else $error("write strobe low too short");
  property p_wr_data; wr_strobe && $past(wr_strobe) |-> $stable(wr_data); endproperty
  a_wr_data: assert property (p_wr_data) else $error("word moved under strobe");
  property p_rd_high; $rose(rd_strobe) |-> s_held(rd_strobe); endproperty
  a_rd_high: assert property (p_rd_high) else $error("read strobe too short");
  property p_rd_low; $fell(rd_strobe) |-> s_rest(rd_strobe); endproperty
  a_rd_low: assert property (p_rd_low) else $error("read strobe low too short");
  property p_rd_drop; $fell(rd_strobe) |-> !$past(data_valid[0]); endproperty
  a_rd_drop: assert property (p_rd_drop) else $error("read released before valid fell");
  property p_latch; $rose(rd_strobe) |-> ##[0:1] snk_valid; endproperty
  a_latch: assert property (p_latch) else $error("word not latched at read rise");
  property p_pulse; snk_valid |=> !snk_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("sink pulse too long");
  property p_quiet; !clear_n |-> !wr_strobe && !rd_strobe && busy_clear; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe during clear");
  property p_clr; $fell(clear_n) |-> !clear_n [*4]; endproperty
  a_clr: assert property (p_clr) else $error("clear pulse too short");
endmodule // fifo_host_checker

bind fifo_host fifo_host_checker #(.WIDTH(WIDTH), .LANES(LANES)) u_chk (
  .clk(clk), .rst(rst), .clear_req(clear_req), .src_valid(src_valid),
  .src_ready(src_ready), .src_data(src_data), .snk_valid(snk_valid),
  .snk_data(snk_data), .busy_clear(busy_clear), .clear_n(clear_n),
  .wr_strobe(wr_strobe), .wr_data(wr_data), .space_available(space_available),
  .rd_strobe(rd_strobe), .data_valid(data_valid), .rd_data(rd_data));

// file: fifo_dev_model.sv
module fifo_dev_model #(
  parameter int W = 5,
  parameter int D = 64
) (
  input wire logic clear_n, // Clear, active low
  input wire logic wr_strobe, // Write strobe
  input wire logic [W-1:0] din, // Input word
  input wire logic rd_strobe, // Read strobe
  output logic space_available, // Room flag
  output logic data_valid, // Output valid
  output logic [W-1:0] dout // Output word
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [W-1:0] q[$];
  logic [W-1:0] w_q;
  logic head_q, skip_q;
  int lag = 20;
  realtime t_first = -100;
  // Word to output, valid only after it settles
  task automatic present(input bit from_empty);
    if (!head_q && q.size() > 0) begin
      head_q = 1;
      dout = q.pop_front();
      if (from_empty) t_first = $realtime;
      #5 data_valid = 1;
    end
  endtask
  // Clear empties the store, zeroes data_valid and dout, and sets space_available
  initial space_available = 1;
  always @(negedge clear_n) begin
    q.delete();
    head_q = 0;
    dout = '0;
    space_available = 1;
    data_valid = 0;
  end
  initial begin
    head_q = 0;
    dout = '0;
    data_valid = 0;
  end
  // Capture on rise, commit and free on fall
  always @(posedge wr_strobe) if (clear_n) begin
    w_q = din;
    #15 space_available = 0;
  end
  always @(negedge wr_strobe) if (clear_n) begin
    q.push_back(w_q);
    // Commit in its own thread so that a later strobe edge is never missed
    fork
      begin
        #(lag);
        space_available = (q.size() + head_q) < D;
        present(1);
      end
    join_none
  end
  // A read inside the window after first valid is not recognised, but a strobe
  // held high past the window is, so the handshake always completes
  always @(posedge rd_strobe) begin
    skip_q = 1;
    while (rd_strobe && ($realtime - t_first) < 40) #1;
    if (rd_strobe) begin
      skip_q = 0;
      #15 data_valid = 0;
    end
  end
  always @(negedge rd_strobe) if (clear_n && !skip_q) begin
    head_q = 0;
    // Advance in its own thread so that a later strobe edge is never missed
    fork
      begin
        #(lag);
        if (!wr_strobe) space_available = 1;
        present(0);
      end
    join_none
  end
endmodule // fifo_dev_model

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, clear_req = 0, src_valid = 0;
  logic [4:0] src_data = '0;
  wire logic src_ready, snk_valid, busy_clear, clear_n, wr_strobe, rd_strobe;
  wire logic [4:0] snk_data, wr_data, rd_data;
  wire logic [0:0] sa, dv;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  logic [4:0] exp_q[$];
  always #5 clk = ~clk;
  fifo_host #(.WIDTH(5), .LANES(1)) dut (.clk(clk), .rst(rst), .clear_req(clear_req),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .snk_valid(snk_valid), .snk_data(snk_data), .busy_clear(busy_clear),
    .clear_n(clear_n), .wr_strobe(wr_strobe), .wr_data(wr_data), .space_available(sa),
    .rd_strobe(rd_strobe), .data_valid(dv), .rd_data(rd_data));
  fifo_dev_model dev (.clear_n(clear_n), .wr_strobe(wr_strobe), .din(wr_data),
    .rd_strobe(rd_strobe), .space_available(sa[0]), .data_valid(dv[0]), .dout(rd_data));
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // Each received word must be the next one sent, sampled mid-cycle
  always @(negedge clk) if (snk_valid === 1'b1) begin
    check(snk_data, exp_q.size() ? exp_q.pop_front() : 8'hff);
  end
  // Offer a word and hold it until taken
  task send(input logic [4:0] d);
    src_valid = 1;
    src_data = d;
    while (src_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    exp_q.push_back(d);
  endtask
  task drain;
    src_valid = 0;
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk);
    repeat (30) @(posedge clk);
    #1;
    check(exp_q.size(), 0);
  endtask
  task t_reset;
    repeat (2) @(posedge clk);
    #1;
    check(clear_n, 0);
    check(rd_data, 0);
    while (busy_clear !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    check({sa, dv}, 2'b10);
    $display("reset test done");
  endtask
  task t_single;
    send(5'h15);
    drain();
    check({rd_data, dv}, {5'h15, 1'b0});
    $display("single word test done");
  endtask
  task t_burst;
    for (int i = 0; i < 12; i++) send(5'(i + 3));
    drain();
    $display("burst test done");
  endtask
  task t_stall;
    dev.lag = 300;
    for (int i = 0; i < 6; i++) send(5'(5'h10 + i));
    src_data = 5'h1e;
    repeat (2) @(posedge clk);
    #1;
    check(src_ready, 0);
    send(5'h1e);
    drain();
    dev.lag = 20;
    $display("stall test done");
  endtask
  task t_clear;
    clear_req = 1;
    @(posedge clk);
    #1;
    clear_req = 0;
    repeat (3) @(posedge clk);
    #1;
    check({clear_n, rd_data, dv}, 0);
    send(5'h0a);
    drain();
    $display("clear test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    t_reset();
    t_single();
    t_burst();
    t_stall();
    t_clear();
    finish_test();
  end
endmodule // tb
